// ===== eipl_pkg.sv
// Constants, register map and carrier types for the external pin interrupt latch.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package eipl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] EIPL_OFS_CTRL  = 8'h00;
  localparam logic [7:0] EIPL_OFS_EVST  = 8'h04;
  localparam logic [7:0] EIPL_OFS_EVMSK = 8'h08;

  // ==========================================================
  // Control/status register fields
  localparam int EIPL_BIT_MODE = 0;
  localparam int EIPL_BIT_MASK = 1;
  localparam int EIPL_BIT_ACK  = 2;
  localparam int EIPL_BIT_PEND = 3;

  // ==========================================================
  // Event status / event mask fields
  localparam int EIPL_EV_LATCH = 0;
  localparam int EIPL_EV_ACK   = 1;
  localparam int EIPL_EV_W     = 2;

  // ==========================================================
  // Reset values
  localparam logic              EIPL_RST_MODE  = 1'b0;
  localparam logic              EIPL_RST_MASK  = 1'b0;
  localparam logic [EIPL_EV_W-1:0] EIPL_RST_EVMSK = 2'h0;

  // ==========================================================
  // Service routine vector pair
  localparam logic [15:0] EIPL_VEC_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] EIPL_VEC_LO_ADDR = 16'hFFFB;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } eipl_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } eipl_apb_rsp_t;

endpackage : eipl_pkg

// ===== eipl_top.sv
// External pin interrupt latch: one active-low pin, edge or edge+level
// sensing, vector-fetch and software acknowledge, mask, APB registers.
// Assumes the pin is asynchronous and all other inputs are synchronous
// to clock; vector_fetch is a one-cycle pulse from the CPU.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

module eipl_top
  import eipl_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // APB slave
  input  wire eipl_apb_req_t apb_req,
  output eipl_apb_rsp_t      apb_rsp,
  // External pin
  input  wire logic          ext_int_pin_n,
  // CPU side
  input  wire logic          vector_fetch,
  input  wire logic          break_state,
  input  wire logic          break_clear_enable,
  output logic               irq_request,
  output logic [15:0]        vector_addr,
  output logic               pin_level,
  // System interrupt
  output logic               irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 sync3;
    logic                 latch;
    logic                 acked;
    logic                 mode;
    logic                 mask;
    logic [EIPL_EV_W-1:0] evst;
    logic [EIPL_EV_W-1:0] evmsk;
    logic                 rdy;
    logic [31:0]          rdata;
    logic                 err;
  } eipl_state_t;

  localparam eipl_state_t EIPL_RST_STATE = '{
    sync1: 1'b1, sync2: 1'b1, sync3: 1'b1,
    latch: 1'b0, acked: 1'b0,
    mode:  EIPL_RST_MODE, mask: EIPL_RST_MASK,
    evst:  '0, evmsk: EIPL_RST_EVMSK,
    rdy:   1'b0, rdata: '0, err: 1'b0
  };

  eipl_state_t st_r;
  eipl_state_t st_nxt;

  // ==========================================================
  // Decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == EIPL_OFS_CTRL) || (a == EIPL_OFS_EVST) ||
                (a == EIPL_OFS_EVMSK);
  endfunction : is_mapped

  function automatic logic [31:0] ctrl_word(input logic mode, input logic mask,
                                            input logic pend);
    ctrl_word = '0;
    ctrl_word[EIPL_BIT_MODE] = mode;
    ctrl_word[EIPL_BIT_MASK] = mask;
    ctrl_word[EIPL_BIT_PEND] = pend;
  endfunction : ctrl_word

  // ==========================================================
  // Combinational terms
  logic pin_low;
  logic fall_edge;
  logic access;
  logic done;
  logic wr_ctrl;
  logic rd_evst;
  logic sw_ack_req;
  logic sw_ack;
  logic any_ack;
  logic set_ev;

  always_comb begin
    pin_low    = ~st_r.sync2;
    fall_edge  = st_r.sync3 & ~st_r.sync2;
    access     = apb_req.psel & apb_req.penable;
    done       = access & st_r.rdy;
    wr_ctrl    = done & apb_req.pwrite & (apb_req.paddr == EIPL_OFS_CTRL);
    rd_evst    = done & ~apb_req.pwrite & (apb_req.paddr == EIPL_OFS_EVST);
    sw_ack_req = wr_ctrl & apb_req.pwdata[EIPL_BIT_ACK];
    // Break protects the latch from software acknowledge unless clearing is enabled
    sw_ack     = sw_ack_req & (~break_state | break_clear_enable);
    any_ack    = vector_fetch | sw_ack;
    set_ev     = fall_edge | (st_r.mode & pin_low);
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;

    // Two-flop synchroniser, third flop only for the edge history
    st_nxt.sync1 = ext_int_pin_n;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;

    // Request latch: setting wins over any acknowledge
    if (set_ev) begin
      st_nxt.latch = 1'b1;
    end else if (any_ack || st_r.acked) begin
      st_nxt.latch = 1'b0;
    end

    // Level mode: remember an acknowledge taken while the pin is low
    st_nxt.acked = st_r.mode & pin_low & st_r.latch &
                   (any_ack | st_r.acked);

    // Control writes
    if (wr_ctrl) begin
      st_nxt.mode = apb_req.pwdata[EIPL_BIT_MODE];
      st_nxt.mask = apb_req.pwdata[EIPL_BIT_MASK];
    end
    if (done && apb_req.pwrite && apb_req.paddr == EIPL_OFS_EVMSK) begin
      st_nxt.evmsk = apb_req.pwdata[EIPL_EV_W-1:0];
    end

    // Sticky events; read clears, a new event in the same cycle wins
    if (rd_evst) begin
      st_nxt.evst = '0;
    end
    if (st_nxt.latch && !st_r.latch) begin
      st_nxt.evst[EIPL_EV_LATCH] = 1'b1;
    end
    if (any_ack && st_r.latch) begin
      st_nxt.evst[EIPL_EV_ACK] = 1'b1;
    end

    // APB: one wait cycle, read data captured into a flop
    st_nxt.rdy = access & ~st_r.rdy;
    if (access && !st_r.rdy) begin
      st_nxt.err = ~is_mapped(apb_req.paddr);
      case (apb_req.paddr)
        EIPL_OFS_CTRL: begin
          st_nxt.rdata = ctrl_word(st_r.mode, st_r.mask, st_r.latch);
        end
        EIPL_OFS_EVST: begin
          st_nxt.rdata = {{(32-EIPL_EV_W){1'b0}}, st_r.evst};
        end
        EIPL_OFS_EVMSK: begin
          st_nxt.rdata = {{(32-EIPL_EV_W){1'b0}}, st_r.evmsk};
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Register the state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= EIPL_RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    apb_rsp.pready  = st_r.rdy;
    apb_rsp.prdata  = st_r.rdata;
    apb_rsp.pslverr = st_r.rdy & st_r.err;
    irq_request     = st_r.latch & ~st_r.mask;
    vector_addr     = EIPL_VEC_HI_ADDR;
    pin_level       = st_r.sync2;
    irq             = |(st_r.evst & st_r.evmsk);
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  sequence s_ctrl_read;
    apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == EIPL_OFS_CTRL;
  endsequence

  AST_EDGE_SETS: assert property (fall_edge |=> st_r.latch)
    else $error("Falling edge did not set the latch");

  AST_EDGE_MODE_ACK: assert property (
    !st_r.mode && st_r.latch && any_ack && !set_ev |=> !st_r.latch)
    else $error("Acknowledge did not clear latch in edge mode");

  AST_VEC_CLEARS: assert property (
    vector_fetch && !set_ev && !st_r.acked && pin_low == 1'b0 |=> !st_r.latch)
    else $error("Vector fetch did not clear latch");

  AST_LEVEL_HOLD: assert property (
    st_r.mode && pin_low |=> st_r.latch [*1] ##1 1'b1)
    else $error("Latch dropped while pin low in level mode");

  AST_LEVEL_NEEDS_HIGH: assert property (
    $fell(st_r.latch) |-> $past(st_r.sync2) || !$past(st_r.mode))
    else $error("Level-mode latch cleared with pin low");

  AST_MASK_BLOCKS: assert property (
    st_r.mask |-> !irq_request)
    else $error("Masked request forwarded");

  AST_PEND_READ: assert property (
    s_ctrl_read |-> apb_rsp.prdata[EIPL_BIT_PEND] == $past(st_r.latch))
    else $error("Pending flag does not follow the latch");

  AST_ACK_READS0: assert property (
    s_ctrl_read |-> !apb_rsp.prdata[EIPL_BIT_ACK])
    else $error("Acknowledge bit read as one");

  AST_BRK_PROTECT: assert property (
    sw_ack_req && break_state && !break_clear_enable && st_r.latch &&
    !vector_fetch |=> st_r.latch)
    else $error("Software acknowledge acted during protected break");

  AST_APB_ONE_WAIT: assert property (
    s_setup ##1 s_access |-> ##1 apb_rsp.pready)
    else $error("APB answer not after one wait cycle");

  // A fall seen at one edge must show as an edge two edges later,
  // whatever the pin does in between: the history flop holds the old level
  AST_SYNC_DELAY: assert property (
    $fell(ext_int_pin_n) |-> ##2 fall_edge)
    else $error("Falling pin edge not detected after synchroniser");

  // ==========================================================
  // Level-mode clearing steps, then reset, latch, control, mask, pin, event and APB checks
  // Each step of the two-part level-mode clear is checked on its own,
  // so a failure points at the half that broke.
  sequence s_level_acked;
    st_r.mode && pin_low && st_r.latch && any_ack;
  endsequence

  sequence s_back_high;
    st_r.acked && !pin_low && !fall_edge;
  endsequence

  AST_LEVEL_ACK_KEPT: assert property (
    s_level_acked |=> st_r.acked)
    else $error("Level-mode acknowledge not remembered");

  AST_LEVEL_CLEARS_HIGH: assert property (
    s_back_high |=> !st_r.latch)
    else $error("Level-mode latch kept after pin returned high");

  // Reset must act even with the pin low, so the usual disable is off here
  AST_RESET_CLEARS: assert property (
    @(posedge clock) disable iff (1'b0)
    !rst_n |=> !st_r.latch && !st_r.mode && !st_r.mask && !apb_rsp.pready)
    else $error("Reset left latch or control bits set");

  AST_SW_ACK_CLEARS: assert property (
    sw_ack && !st_r.mode && !set_ev |=> !st_r.latch)
    else $error("Software acknowledge did not clear latch");

  AST_ONLY_ACK_CLEARS: assert property (
    wr_ctrl && !apb_req.pwdata[EIPL_BIT_ACK] && st_r.latch && !vector_fetch &&
    !st_r.acked |=> st_r.latch)
    else $error("Control write without acknowledge cleared latch");

  AST_EDGE_AFTER_ACK: assert property (
    fall_edge && sw_ack |=> st_r.latch)
    else $error("Edge together with acknowledge was lost");

  AST_VEC_IN_BREAK: assert property (
    vector_fetch && break_state && !st_r.mode && !set_ev |=> !st_r.latch)
    else $error("Vector fetch in break did not clear latch");

  AST_BRK_CLEAR_OK: assert property (
    sw_ack_req && break_state && break_clear_enable && !st_r.mode &&
    !set_ev |=> !st_r.latch)
    else $error("Enabled software acknowledge failed in break");

  AST_STAYS_CLEAR: assert property (
    !st_r.latch && !set_ev |=> !st_r.latch)
    else $error("Latch set with no qualifying pin event");

  AST_UNMASKED_FORWARDS: assert property (
    st_r.latch && !st_r.mask |-> irq_request)
    else $error("Unmasked request not forwarded");

  AST_NO_LATCH_NO_REQ: assert property (
    !st_r.latch |-> !irq_request)
    else $error("Request forwarded with latch clear");

  AST_MASK_KEEPS_LATCH: assert property (
    st_r.mask && st_r.latch && !any_ack && !st_r.acked |=> st_r.latch)
    else $error("Mask disturbed the latched request");

  AST_MODE_WRITE: assert property (
    wr_ctrl |=> st_r.mode == $past(apb_req.pwdata[EIPL_BIT_MODE]))
    else $error("Sensitivity bit not written");

  AST_MASK_WRITE: assert property (
    wr_ctrl |=> st_r.mask == $past(apb_req.pwdata[EIPL_BIT_MASK]))
    else $error("Mask bit not written");

  // Two clean cycles after reset before the synchroniser shows the pin
  AST_PIN_LEVEL: assert property (
    $past(rst_n, 2) && $past(rst_n) |-> pin_level == $past(ext_int_pin_n, 2))
    else $error("Presented pin level does not follow the pin");

  AST_VECTOR_PAIR: assert property (
    irq_request |-> vector_addr == EIPL_VEC_HI_ADDR)
    else $error("Wrong service routine vector");

  AST_EV_LATCH_SET: assert property (
    $rose(st_r.latch) |-> st_r.evst[EIPL_EV_LATCH])
    else $error("Latch event not recorded");

  AST_EV_ACK_SET: assert property (
    any_ack && st_r.latch |=> st_r.evst[EIPL_EV_ACK])
    else $error("Acknowledge event not recorded");

  AST_EV_STICKY: assert property (
    st_r.evst[EIPL_EV_LATCH] && !rd_evst |=> st_r.evst[EIPL_EV_LATCH])
    else $error("Latch event lost without a read");

  AST_EV_READ_CLEARS: assert property (
    rd_evst && !(st_nxt.latch && !st_r.latch) && !(any_ack && st_r.latch)
    |=> st_r.evst == '0)
    else $error("Event status not cleared by read");

  AST_ERR_UNMAPPED: assert property (
    apb_rsp.pready && !is_mapped(apb_req.paddr) |-> apb_rsp.pslverr)
    else $error("Unmapped access without error");

  AST_ERR_MAPPED: assert property (
    apb_rsp.pready && is_mapped(apb_req.paddr) |-> !apb_rsp.pslverr)
    else $error("Mapped access flagged as error");

  AST_READY_ONE_CYCLE: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("Ready held longer than one cycle");

  AST_NO_READY_IDLE: assert property (
    !apb_req.psel |=> !apb_rsp.pready)
    else $error("Ready raised without a transfer");

endmodule : eipl_top

// ===== eipl_pin_src.sv
// Model of the source that drives the active-low interrupt pin.
// Assumes commands from the bench arrive at rising clock edges.
`timescale 1ns/1ps
module eipl_pin_src (
  // Control
  input  wire logic clock,
  input  wire logic drive_low,
  input  wire logic slow,
  // Pin
  output logic      pin_n = 1'b1
);
  logic lag_r = 1'b0;
  // ==========================
  // Pull-up keeps the pin high when released; slow adds one cycle
  always @(posedge clock) begin
    lag_r <= drive_low;
    pin_n <= ~(slow ? lag_r : drive_low);
  end
endmodule : eipl_pin_src

// ===== eipl_tb_top.sv
// Testbench for the external pin interrupt latch.
// Assumes an APB slave answering with pready and a pin source model.
`timescale 1ns/1ps
module eipl_tb_top;
  import eipl_pkg::*;
  localparam logic [31:0] MOD = 32'h1 << EIPL_BIT_MODE;
  localparam logic [31:0] MSK = 32'h1 << EIPL_BIT_MASK;
  localparam logic [31:0] ACK = 32'h1 << EIPL_BIT_ACK;
  localparam logic [31:0] PND = 32'h1 << EIPL_BIT_PEND;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  eipl_apb_req_t req = '0;
  eipl_apb_rsp_t rsp;
  logic          pin_low = 1'b0, slow = 1'b0, vf = 1'b0;
  logic          brk = 1'b0, bce = 1'b0;
  logic          pin_n, irq_req, pin_lvl, irq, er;
  logic [15:0]   vaddr;
  logic [31:0]   rd;
  int            err_total = 0, checks = 0;
  always #5 clock = ~clock;
  eipl_pin_src SRC (.clock(clock), .drive_low(pin_low), .slow(slow), .pin_n(pin_n));
  eipl_top DUT (.clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .ext_int_pin_n(pin_n), .vector_fetch(vf), .break_state(brk),
    .break_clear_enable(bce), .irq_request(irq_req), .vector_addr(vaddr),
    .pin_level(pin_lvl), .irq(irq));
  // ==========================
  // Helpers
  task give_verdict;
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Outputs are looked at on the falling edge, once settled
  task tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : tick
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (n >= 20) chk(32'h0, 32'h1);
    tick(0);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task pin(input logic v);
    @(posedge clock) pin_low <= v;
    tick(8);
  endtask : pin
  task vfetch;
    @(posedge clock) vf <= 1'b1;
    @(posedge clock) vf <= 1'b0;
    tick(1);
  endtask : vfetch
  // ==========================
  // Tests
  initial begin
    tick(16);
    @(posedge clock) rst_n <= 1'b1;
    rdc(EIPL_OFS_CTRL, 32'h0);
    rdc(EIPL_OFS_EVMSK, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 32'h1);
    chk(pin_lvl, 32'h1);
    wr(EIPL_OFS_EVMSK, 32'h1);
    pin(1'b1);
    chk(pin_lvl, 32'h0);
    chk(irq_req, 32'h1);
    chk(irq, 32'h1);
    chk(vaddr, 32'hFFFA);
    wr(EIPL_OFS_CTRL, MSK);
    chk(irq_req, 32'h0);
    rdc(EIPL_OFS_CTRL, MSK | PND);
    rdc(EIPL_OFS_EVST, 32'h1);
    chk(irq, 32'h0);
    wr(EIPL_OFS_CTRL, MSK | ACK);
    rdc(EIPL_OFS_CTRL, MSK);
    wr(EIPL_OFS_CTRL, 32'h0);
    pin(1'b0);
    pin(1'b1);
    chk(irq_req, 32'h1);
    vfetch;
    chk(irq_req, 32'h0);
    pin(1'b0);
    // Edge and level sensing, slow pin source
    wr(EIPL_OFS_CTRL, MOD);
    rdc(EIPL_OFS_CTRL, MOD);
    @(posedge clock) slow <= 1'b1;
    pin(1'b1);
    vfetch;
    tick(10);
    chk(irq_req, 32'h1);
    pin(1'b0);
    chk(irq_req, 32'h0);
    pin(1'b1);
    pin(1'b0);
    chk(irq_req, 32'h1);
    pin(1'b1);
    wr(EIPL_OFS_CTRL, MOD | ACK);
    rdc(EIPL_OFS_CTRL, MOD | PND);
    // Reset with the pin low
    @(posedge clock) rst_n <= 1'b0;
    tick(4);
    chk(irq_req, 32'h0);
    pin(1'b0);
    @(posedge clock) rst_n <= 1'b1;
    rdc(EIPL_OFS_CTRL, 32'h0);
    // Break state
    @(posedge clock) brk <= 1'b1;
    pin(1'b1);
    wr(EIPL_OFS_CTRL, ACK);
    rdc(EIPL_OFS_CTRL, PND);
    @(posedge clock) bce <= 1'b1;
    wr(EIPL_OFS_CTRL, ACK);
    @(posedge clock) brk <= 1'b0;
    tick(4);
    rdc(EIPL_OFS_CTRL, 32'h0);
    give_verdict;
  end
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    tick(3000);
    err_total++;
    give_verdict;
  end
endmodule : eipl_tb_top
